// *** src/wfs_corr.sv ***
// masked chip correlator: compares the newest chips with a pattern
`timescale 1ns/1ps
module wfs_corr #(
    parameter int CORR_LEN = 16
) (
    input  wire logic [CORR_LEN-1:0]      window,  // newest chip at bit 0
    input  wire logic [CORR_LEN-1:0]      pattern, // expected chips
    input  wire logic [wfs_pkg::LEN_W-1:0] length, // active chips, 0 = off
    output logic                          match    // the low length chips of window equal pattern
);
    import wfs_pkg::*;

    logic [CORR_LEN-1:0] mask;

    if (CORR_LEN < 1 || CORR_LEN >= (1 << LEN_W)) begin : g_bad_len
        $error("wfs_corr: CORR_LEN out of range");
    end

    always_comb begin
        for (int i = 0; i < CORR_LEN; i++) begin
            mask[i] = (i < int'(length));
        end
        match = (length != '0) && (((window ^ pattern) & mask) == '0);
    end

endmodule // wfs_corr

// *** src/wfs_frame_sync.sv ***
// wake-up decision and telegram start identifier search
// Notes on behaviour
// R1 - default blocking thresholds disable level blocking
// R2 - software sizes observation time for path delay
// R3 - consecutive recognition samples reach threshold, wake
// R4 - wake search needs sync before timeout
// R5 - sync loss aborts wake search at once
// R6 - window counter counts units, equal means elapsed
// R7 - three equal chips flag a code violation
// R8 - sixteen newest units equal pattern, wake
// R9 - pattern search stops on window or sync loss
// R10 - software sets window count at least 0x11
// R11 - bit mode pattern, code violation aborts
// R12 - software avoids equal/pattern in slicer bit mode
// R13 - one of four wake criteria is applied
// R14 - equal bits: change, violation or loss stops
// R15 - random bits: count without violation wakes
// R16 - valid rate: sync reached means wake
// R17 - four identifier modes from mode register
// R18 - search starts on sync or wake, ends
// R19 - two sixteen-chip correlators with length, pattern
// R20 - software sets first length sixteen when chained
// R21 - parallel: first matching correlator raises sync
// R22 - extended: tag bit names matching correlator
// R23 - gap mode: second match after gap
// R24 - comparison register cleared after the gap
// R25 - single pulse; shift registers cleared on start
`timescale 1ns/1ps
module wfs_frame_sync (
    input  wire logic              ref_clk, // baseband clock
    input  wire logic              nrst,    // async reset, active low
    input  wire wfs_pkg::wfs_rx_t  rx,      // chips, bits and levels from recovery
    input  wire wfs_pkg::wfs_bus_t bus,     // register port request
    output logic [7:0]             rdData,  // read data, cycle after read strobe
    output wfs_pkg::wfs_evt_t      evt      // wake and frame events
);
    import wfs_pkg::*;

    typedef struct packed {
        wfs_fsm_t                 fsm;
        logic [CFG_NUM-1:0][7:0]  cfg;
        logic [7:0]               rdData;
        logic [CORR_W-1:0]        wakeShift;
        logic [2*CORR_W-1:0]      identShift;
        logic [7:0]               winCnt;
        logic [7:0]               obsCnt;
        logic [7:0]               recCnt;
        logic [7:0]               gapCnt;
        logic [2:0]               chipHist;
        logic [1:0]               histCnt;
        logic                     lastBit;
        logic                     bitSeen;
        logic                     prevSync;
        logic                     wakeDone;
        logic                     frameDone;
        logic                     matchedB;
        wfs_evt_t                 evt;
    } wfs_regs_t;

    localparam logic [CFG_NUM*8-1:0] CFG_RST =
        (CFG_NUM*8)'(BLOCK_LOW_RST) << (8 * int'(A_BLOCK_LOW)) |
        (CFG_NUM*8)'(BLOCK_HIGH_RST) << (8 * int'(A_BLOCK_HIGH));

    wfs_regs_t r;
    wfs_regs_t next_r;

    function automatic logic [7:0] cfgAt(input wfs_regs_t s, input logic [4:0] idx);
        return s.cfg[idx[3:0]];
    endfunction

    function automatic logic [15:0] pair(input wfs_regs_t s, input logic [4:0] lo);
        return {s.cfg[4'(lo[3:0] + 4'h1)], s.cfg[lo[3:0]]};
    endfunction

    // configuration views
    logic              enable, selfPoll, patBitMode, rssiEn, sigRecEn;
    wfs_crit_t         crit;
    wfs_ident_t        identMode;
    logic [LEN_W-1:0]  lenA, lenB;

    assign enable     = cfgAt(r, A_WAKE_CTRL)[WC_ENABLE];
    assign selfPoll   = cfgAt(r, A_WAKE_CTRL)[WC_SELF_POLL];
    assign patBitMode = cfgAt(r, A_WAKE_CTRL)[WC_PAT_BIT];
    assign rssiEn     = cfgAt(r, A_WAKE_CTRL)[WC_RSSI_EN];
    assign sigRecEn   = cfgAt(r, A_WAKE_CTRL)[WC_SIGREC_EN];
    assign crit       = wfs_crit_t'(cfgAt(r, A_WAKE_CTRL)[WC_CRIT_LSB +: 2]); // see R13
    assign identMode  = wfs_ident_t'(cfgAt(r, A_FRAME_CTRL)[FC_MODE_LSB +: 2]); // see R17
    assign lenA       = cfgAt(r, A_LEN_FIRST)[LEN_W-1:0];
    assign lenB       = cfgAt(r, A_LEN_SECOND)[LEN_W-1:0];

    // shift values including the chip or bit of this cycle
    logic [2*CORR_W-1:0] shiftNow;
    logic [CORR_W-1:0]   wakeNow, winA, winB;
    logic                unitStrobe, unitVal, hitA, hitB, hitWake;

    assign unitStrobe = (crit == CRIT_PATTERN && !patBitMode) ? rx.chipStrobe : rx.bitStrobe;
    assign unitVal    = (crit == CRIT_PATTERN && !patBitMode) ? rx.chip : rx.dataBit;
    assign shiftNow   = rx.chipStrobe ? {r.identShift[2*CORR_W-2:0], rx.chip} : r.identShift;
    assign wakeNow    = unitStrobe ? {r.wakeShift[CORR_W-2:0], unitVal} : r.wakeShift;
    // single mode chains first correlator behind the second
    assign winA = (identMode == ID_SINGLE) ? CORR_W'(shiftNow >> lenB) : shiftNow[CORR_W-1:0];
    assign winB = shiftNow[CORR_W-1:0];

    wfs_corr #(.CORR_LEN(CORR_W)) u_corr_a ( // see R19
        .window  (winA),
        .pattern (pair(r, A_PATA_LOW)),
        .length  (lenA),
        .match   (hitA)
    );
    wfs_corr #(.CORR_LEN(CORR_W)) u_corr_b ( // see R19
        .window  (winB),
        .pattern (pair(r, A_PATB_LOW)),
        .length  (lenB),
        .match   (hitB)
    );
    wfs_corr #(.CORR_LEN(CORR_W)) u_corr_wake ( // see R8
        .window  (wakeNow),
        .pattern (pair(r, A_WPAT_LOW)),
        .length  (LEN_W'(CORR_W)),
        .match   (hitWake)
    );

    always_comb begin
        logic [2:0] hist;
        logic [7:0] recNext;
        logic       cv, syncLost, winDone, levelWake, blocked, obsOpen;
        logic       wakeHit, wakeAbort, frameHit, startFrame, restart;
        hist       = {r.chipHist[1:0], rx.chip};
        syncLost   = r.prevSync && !rx.symSync;
        recNext    = '0;
        {cv, winDone, levelWake, blocked, obsOpen} = '0;
        {wakeHit, wakeAbort, frameHit, startFrame, restart} = '0;
        next_r     = r;

        next_r.rdData   = '0;
        next_r.evt      = '0;
        next_r.prevSync = rx.symSync;

        // register port
        if (bus.wr && bus.addr < ADDR_W'(CFG_NUM)) begin
            next_r.cfg[bus.addr[3:0]] = bus.wdata;
        end
        if (bus.rd) begin
            if (bus.addr < ADDR_W'(CFG_NUM)) begin
                next_r.rdData = r.cfg[bus.addr[3:0]];
            end else if (bus.addr == A_STATUS) begin
                next_r.rdData[SB_WAKE]          = r.wakeDone;
                next_r.rdData[SB_FRAME]         = r.frameDone;
                next_r.rdData[SB_MATCH_B]       = r.matchedB;
                next_r.rdData[SB_STATE_LSB +: 4] = r.fsm;
            end
        end
        // write one clears sticky flags; hardware set below wins
        if (bus.wr && bus.addr == A_STATUS) begin
            if (bus.wdata[SB_WAKE])    next_r.wakeDone  = 1'b0;
            if (bus.wdata[SB_FRAME])   next_r.frameDone = 1'b0;
            if (bus.wdata[SB_MATCH_B]) next_r.matchedB  = 1'b0;
        end

        // code violation detector
        if (rx.chipStrobe) begin
            next_r.chipHist = hist;
            if (r.histCnt != CV_HIST_FULL) begin
                next_r.histCnt = r.histCnt + 2'h1;
            end else begin
                cv = (hist == 3'b111) || (hist == 3'b000); // see R7
            end
        end

        // level criteria during the observation time
        obsOpen = r.obsCnt < cfgAt(r, A_OBS_TIME);
        blocked = rx.rssi >= cfgAt(r, A_BLOCK_LOW) && rx.rssi <= cfgAt(r, A_BLOCK_HIGH); // see R1
        recNext = (rx.sigRecog && r.recCnt != 8'hff) ? r.recCnt + 8'h01 : r.recCnt;
        if (!rx.sigRecog) begin
            recNext = '0;
        end
        if (rx.sixteenthStrobe && obsOpen) begin
            next_r.obsCnt = r.obsCnt + 8'h01;
            next_r.recCnt = recNext;
            if (sigRecEn && rx.sigRecog && recNext == cfgAt(r, A_BLOCK_HIGH)) begin
                levelWake = 1'b1; // see R3
            end
        end
        if (rssiEn && obsOpen && rx.rssi >= cfgAt(r, A_LEVEL_THR) && !blocked) begin
            levelWake = 1'b1;
        end

        // wake window counter
        if (unitStrobe) begin
            next_r.wakeShift = wakeNow;
            next_r.winCnt    = r.winCnt + 8'h01;
            winDone          = (r.winCnt + 8'h01) == cfgAt(r, A_WIN_COUNT); // see R6
        end

        case (r.fsm)
            FS_IDLE: begin
                if (enable && selfPoll) begin
                    next_r.fsm = FS_WAKE_SYNC;
                end else if (enable && rx.symSync) begin
                    startFrame = 1'b1; // see R18
                end
            end
            FS_WAKE_SYNC: begin
                if (levelWake) begin
                    wakeHit = 1'b1;
                end else if (rx.symSync) begin
                    if (crit == CRIT_RATE) begin
                        wakeHit = 1'b1; // see R16
                    end else begin
                        next_r.fsm     = FS_WAKE_SEARCH; // see R4
                        next_r.winCnt  = '0;
                        next_r.bitSeen = 1'b0;
                    end
                end else if (rx.syncTimeout) begin
                    restart = 1'b1; // see R4
                end
            end
            FS_WAKE_SEARCH: begin
                if (levelWake) begin
                    wakeHit = 1'b1;
                end else if (syncLost) begin
                    wakeAbort = 1'b1; // see R5
                end else begin
                    case (crit)
                        CRIT_PATTERN: begin
                            if (unitStrobe && hitWake) begin
                                wakeHit = 1'b1; // see R8
                            end else if (cv && patBitMode) begin
                                wakeAbort = 1'b1; // see R11
                            end else if (winDone) begin
                                wakeAbort = 1'b1; // see R9
                            end
                        end
                        CRIT_EQUAL: begin
                            if (cv || (rx.bitStrobe && r.bitSeen && rx.dataBit != r.lastBit)) begin
                                wakeAbort = 1'b1; // see R14
                            end else if (winDone) begin
                                wakeHit = 1'b1; // see R14
                            end
                        end
                        CRIT_RANDOM: begin
                            if (cv) begin
                                wakeAbort = 1'b1; // see R15
                            end else if (winDone) begin
                                wakeHit = 1'b1; // see R15
                            end
                        end
                        default: begin
                            wakeHit = 1'b1;
                        end
                    endcase
                end
                if (rx.bitStrobe) begin
                    next_r.lastBit = rx.dataBit;
                    next_r.bitSeen = 1'b1;
                end
            end
            FS_FRAME: begin
                if (syncLost) begin
                    restart = 1'b1; // see R18
                end else if (rx.chipStrobe) begin
                    next_r.identShift = shiftNow;
                    case (identMode)
                        ID_SINGLE: begin
                            frameHit = hitA && (lenB == '0 || hitB); // see R17
                        end
                        ID_GAP: begin
                            if (hitA) begin
                                next_r.fsm    = FS_GAP; // see R23
                                next_r.gapCnt = '0;
                            end
                        end
                        default: begin
                            // first correlator wins a tie
                            frameHit        = hitA || hitB; // see R21
                            next_r.matchedB = !hitA && hitB;
                            if (identMode == ID_EXTENDED && frameHit) begin
                                next_r.evt.tagValid = 1'b1; // see R22
                                next_r.evt.tagBit   = !hitA;
                            end
                        end
                    endcase
                end
            end
            FS_GAP: begin
                if (syncLost) begin
                    restart = 1'b1;
                end else if (rx.chipStrobe) begin
                    next_r.gapCnt = r.gapCnt + 8'h01;
                    if (r.gapCnt + 8'h01 >= cfgAt(r, A_GAP_LEN)) begin
                        next_r.identShift = '0; // see R24
                        next_r.winCnt     = '0;
                        next_r.fsm        = FS_SECOND;
                    end
                end
            end
            FS_SECOND: begin
                if (syncLost) begin
                    restart = 1'b1;
                end else if (rx.chipStrobe) begin
                    next_r.identShift = shiftNow;
                    next_r.winCnt     = r.winCnt + 8'h01;
                    if (hitB) begin
                        frameHit        = 1'b1; // see R23
                        next_r.matchedB = 1'b1;
                    end else if (r.winCnt + 8'h01 >= 8'(lenB) + GAP_B_SLACK) begin
                        next_r.identShift = '0;
                        next_r.fsm        = FS_FRAME;
                    end
                end
            end
            FS_DONE: begin
                if (syncLost) begin
                    restart = 1'b1;
                end
            end
            default: begin
                restart = 1'b1;
            end
        endcase

        if (wakeHit) begin
            next_r.evt.wakePulse = 1'b1;
            next_r.wakeDone      = 1'b1;
            startFrame           = 1'b1; // see R18
        end
        if (wakeAbort) begin
            restart = 1'b1;
        end
        if (frameHit) begin
            next_r.evt.frameSyncPulse = 1'b1; // see R25
            next_r.evt.matchedSecond  = next_r.matchedB;
            next_r.frameDone          = 1'b1;
            next_r.fsm                = FS_DONE;
        end
        if (startFrame) begin
            next_r.fsm        = FS_FRAME;
            next_r.identShift = '0; // see R25
            next_r.matchedB   = 1'b0;
        end
        if (restart || !enable) begin
            next_r.fsm        = FS_IDLE;
            next_r.identShift = '0; // see R25
            next_r.wakeShift  = '0;
            next_r.winCnt     = '0;
            next_r.obsCnt     = '0;
            next_r.recCnt     = '0;
            next_r.histCnt    = '0;
            next_r.bitSeen    = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            r     <= '0;
            r.cfg <= CFG_RST;
            r.fsm <= FS_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign rdData = r.rdData;
    assign evt    = r.evt;

endmodule // wfs_frame_sync

// *** src/wfs_pkg.sv ***
// package: constants, enums and carrier structs of the wake-up and frame sync block
package wfs_pkg;

    // register indices on the plain register port
    localparam int         ADDR_W         = 5;
    localparam int         CFG_NUM        = 16;
    localparam logic [4:0] A_WAKE_CTRL    = 5'h00;
    localparam logic [4:0] A_FRAME_CTRL   = 5'h01;
    localparam logic [4:0] A_LEVEL_THR    = 5'h02;
    localparam logic [4:0] A_BLOCK_LOW    = 5'h03;
    localparam logic [4:0] A_BLOCK_HIGH   = 5'h04;
    localparam logic [4:0] A_OBS_TIME     = 5'h05;
    localparam logic [4:0] A_WIN_COUNT    = 5'h06;
    localparam logic [4:0] A_WPAT_LOW     = 5'h07;
    localparam logic [4:0] A_WPAT_HIGH    = 5'h08;
    localparam logic [4:0] A_LEN_FIRST    = 5'h09;
    localparam logic [4:0] A_LEN_SECOND   = 5'h0a;
    localparam logic [4:0] A_PATA_LOW     = 5'h0b;
    localparam logic [4:0] A_PATA_HIGH    = 5'h0c;
    localparam logic [4:0] A_PATB_LOW     = 5'h0d;
    localparam logic [4:0] A_PATB_HIGH    = 5'h0e;
    localparam logic [4:0] A_GAP_LEN      = 5'h0f;
    localparam logic [4:0] A_STATUS       = 5'h10;

    // wake control and frame control fields
    localparam int         WC_ENABLE      = 0;
    localparam int         WC_SELF_POLL   = 1;
    localparam int         WC_CRIT_LSB    = 2;
    localparam int         WC_PAT_BIT     = 4;
    localparam int         WC_RSSI_EN     = 5;
    localparam int         WC_SIGREC_EN   = 6;
    localparam int         FC_MODE_LSB    = 0;
    // status fields
    localparam int         SB_WAKE        = 0;
    localparam int         SB_FRAME       = 1;
    localparam int         SB_MATCH_B     = 2;
    localparam int         SB_STATE_LSB   = 4;

    // reset values: blocking window disabled
    localparam logic [7:0] BLOCK_LOW_RST  = 8'hff;
    localparam logic [7:0] BLOCK_HIGH_RST = 8'h00;

    localparam int         CORR_W         = 16;
    localparam int         LEN_W          = 5;
    localparam logic [7:0] GAP_B_SLACK    = 8'h08;
    localparam logic [1:0] CV_HIST_FULL   = 2'h2;

    typedef enum logic [1:0] {CRIT_PATTERN, CRIT_EQUAL, CRIT_RANDOM, CRIT_RATE} wfs_crit_t;
    typedef enum logic [1:0] {ID_SINGLE, ID_PARALLEL, ID_EXTENDED, ID_GAP} wfs_ident_t;
    typedef enum logic [3:0] {
        FS_IDLE, FS_WAKE_SYNC, FS_WAKE_SEARCH, FS_FRAME, FS_GAP, FS_SECOND, FS_DONE
    } wfs_fsm_t;

    typedef struct packed {
        logic       chip;
        logic       chipStrobe;
        logic       dataBit;
        logic       bitStrobe;
        logic       symSync;
        logic       syncTimeout;
        logic       sixteenthStrobe;
        logic       sigRecog;
        logic [7:0] rssi;
    } wfs_rx_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } wfs_bus_t;

    typedef struct packed {
        logic frameSyncPulse;
        logic matchedSecond;
        logic tagValid;
        logic tagBit;
        logic wakePulse;
    } wfs_evt_t;

endpackage

// *** tb/wfs_frame_sync_props.sv ***
// checker: port-level properties of the wake-up and frame sync block
`timescale 1ns/1ps
module wfs_frame_sync_props (
    input wire logic              ref_clk, // baseband clock
    input wire logic              nrst,    // async reset, active low
    input wire wfs_pkg::wfs_rx_t  rx,      // recovery inputs
    input wire wfs_pkg::wfs_bus_t bus,     // register port
    input wire logic [7:0]        rdData,  // read data
    input wire wfs_pkg::wfs_evt_t evt      // events
);
    import wfs_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_frame_one_cycle: assert property (evt.frameSyncPulse |=> !evt.frameSyncPulse)
        else $error("frame pulse longer than one cycle");
    a_frame_after_strobe: assert property (evt.frameSyncPulse |-> $past(rx.chipStrobe))
        else $error("frame pulse without a completing chip strobe");
    a_frame_in_sync: assert property (evt.frameSyncPulse |-> $past(rx.symSync))
        else $error("frame pulse while sync was lost");
    a_tag_with_frame: assert property (evt.tagValid |-> evt.frameSyncPulse)
        else $error("tag bit outside a frame pulse");
    a_tag_names_corr: assert property (evt.tagValid |-> evt.tagBit == evt.matchedSecond)
        else $error("tag bit does not name the matching correlator");
    a_second_with_frame: assert property (evt.matchedSecond |-> evt.frameSyncPulse)
        else $error("second match flag without frame pulse");
    a_wake_one_cycle: assert property (evt.wakePulse |=> !evt.wakePulse)
        else $error("wake pulse longer than one cycle");
    a_read_idle_zero: assert property (!$past(bus.rd) |-> rdData == 8'h00)
        else $error("read data outside the read answer cycle");
    a_unmapped_zero: assert property (bus.rd && bus.addr > A_STATUS |=> rdData == 8'h00)
        else $error("unmapped read not zero");
    c_tag_second: cover property (evt.tagValid && evt.tagBit);
    c_wake: cover property (evt.wakePulse);
    c_par_second: cover property (evt.frameSyncPulse && evt.matchedSecond && !evt.tagValid);
endmodule // wfs_frame_sync_props

bind wfs_frame_sync wfs_frame_sync_props u_wfs_frame_sync_props (.ref_clk(ref_clk),
    .nrst(nrst), .rx(rx), .bus(bus), .rdData(rdData), .evt(evt));

// *** tb/wfs_frame_sync_tb.sv ***
// testbench of the wake-up and frame sync block
`timescale 1ns/1ps
module wfs_frame_sync_tb;
    import wfs_pkg::*;
    logic             ref_clk, nrst, go, mChip, mStb, symSync, syncTimeout;
    logic [31:0]      pat;
    wfs_bus_t         bus;
    wfs_rx_t          rx;
    wfs_evt_t         evt;
    logic [7:0]       rdData;
    int               fail_count, n_checks, m, s;
    localparam logic [31:0] PA = 32'h0000b38e;
    localparam logic [31:0] PB = 32'h000071d4;

    assign rx = '{chip: mChip, chipStrobe: mStb, dataBit: 1'b0, bitStrobe: 1'b0,
                  symSync: symSync, syncTimeout: syncTimeout, sixteenthStrobe: 1'b0,
                  sigRecog: 1'b0, rssi: 8'h00};

    wfs_frame_sync u_wfs_frame_sync (.ref_clk(ref_clk), .nrst(nrst), .rx(rx), .bus(bus),
        .rdData(rdData), .evt(evt));
    wfs_rx_model u_wfs_rx_model (.ref_clk(ref_clk), .nrst(nrst), .start(go), .pattern(pat),
        .nChips(6'd16), .chip(mChip), .chipStrobe(mStb));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge ref_clk);
        bus.wr <= 1'b0;
        // let an edge pass so a following call never re-raises the strobe in this step
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        @(negedge ref_clk);
        chk("rdData", rdData, exp);
        @(posedge ref_clk);
    endtask

    task automatic resync();
        symSync <= 1'b0;
        repeat (3) @(posedge ref_clk);
        symSync <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask

    // send sixteen chips and wait for the frame pulse
    task automatic send(input logic [31:0] p, input logic sec, input logic tg);
        logic hit;
        pat <= p;
        go  <= 1'b1;
        @(posedge ref_clk);
        go  <= 1'b0;
        hit = 1'b0;
        for (int i = 0; i < 200 && !hit; i++) begin
            @(negedge ref_clk);
            if (evt.frameSyncPulse === 1'b1) begin
                hit = 1'b1;
                chk("second", 8'(evt.matchedSecond), 8'(sec));
                chk("tagValid", 8'(evt.tagValid), 8'(tg));
                chk("tagBit", 8'(evt.tagBit & tg), 8'(sec & tg));
            end
        end
        chk("frame", 8'(hit), 8'h01);
        @(posedge ref_clk);
        $display("test frame %h done", p[15:0]);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        end_of_test();
    end

    initial begin
        logic hit;
        fail_count = 0;
        n_checks = 0;
        nrst = 1'b0;
        go = 1'b0;
        pat = 32'h0;
        symSync = 1'b0;
        syncTimeout = 1'b0;
        bus = '0;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rd(A_BLOCK_LOW, BLOCK_LOW_RST);
        rd(A_BLOCK_HIGH, BLOCK_HIGH_RST);
        wr(A_LEVEL_THR, 8'h5a);
        rd(A_LEVEL_THR, 8'h5a);
        rd(5'h11, 8'h00);
        wr(A_WIN_COUNT, 8'h11);
        wr(A_OBS_TIME, 8'h00);
        wr(A_LEN_FIRST, 8'h10);
        wr(A_PATA_LOW, PA[7:0]);
        wr(A_PATA_HIGH, PA[15:8]);
        wr(A_PATB_LOW, PB[7:0]);
        wr(A_PATB_HIGH, PB[15:8]);
        wr(A_WAKE_CTRL, 8'h01);
        resync();
        send(PA, 1'b0, 1'b0);
        rd(A_STATUS, 8'h62);
        wr(A_LEN_SECOND, 8'h10);
        for (m = 1; m < 3; m++) begin
            for (s = 0; s < 2; s++) begin
                wr(A_FRAME_CTRL, 8'(m));
                resync();
                send(s ? PB : PA, 1'(s), 1'(m == 2));
            end
        end
        // self polling with the data rate criterion
        wr(A_WAKE_CTRL, 8'h0f);
        // drop sync, then watch from the edge that brings it back
        symSync <= 1'b0;
        repeat (3) @(posedge ref_clk);
        symSync <= 1'b1;
        hit = 1'b0;
        for (int i = 0; i < 100 && !hit; i++) begin
            @(negedge ref_clk);
            hit = (evt.wakePulse === 1'b1);
        end
        chk("wake", 8'(hit), 8'h01);
        @(posedge ref_clk);
        $display("test wake done");
        send(PA, 1'b0, 1'b1);
        end_of_test();
    end
endmodule // wfs_frame_sync_tb

// *** tb/wfs_rx_model.sv ***
// recovery model: sends a chip sequence with one strobe every four cycles
`timescale 1ns/1ps
module wfs_rx_model (
    input  wire logic        ref_clk,    // baseband clock
    input  wire logic        nrst,       // async reset, active low
    input  wire logic        start,      // begin a sequence
    input  wire logic [31:0] pattern,    // chips, oldest at index nChips-1
    input  wire logic [5:0]  nChips,     // chips to send
    output logic             chip,       // chip value
    output logic             chipStrobe  // one pulse per chip
);
    logic [5:0] left;
    logic [1:0] div;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            left       <= 6'h00;
            div        <= 2'h0;
            chip       <= 1'b0;
            chipStrobe <= 1'b0;
        end else begin
            chipStrobe <= 1'b0;
            div        <= div + 2'h1;
            if (start) begin
                left <= nChips;
                div  <= 2'h0;
            end else if (left != 6'h00 && div == 2'h3) begin
                chip       <= pattern[left-6'h01];
                chipStrobe <= 1'b1;
                left       <= left - 6'h01;
            end else begin
                // line is not valid between strobes
                chip <= ~chip;
            end
        end
    end
endmodule // wfs_rx_model
